/* sfm_pkg.sv */
// Package for the fault-state manager: levels, lamp codes, timing counts.
// Assumes a 100 MHz system clock.
package sfm_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned SLOW_HZ = 1;
  localparam int unsigned FAST_HZ = 2;
  // Half period of each flash rate, in clock cycles (50 % duty)
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned PWR_OFF_MIN_S = 3;
  localparam int unsigned PWR_OFF_CYC = PWR_OFF_MIN_S * CLK_HZ;
  localparam int unsigned DIV_W = 32;
  localparam int unsigned NUM_OUT = 8;
  localparam int unsigned NUM_PAIR = 4;
  localparam int unsigned NUM_IN = 8;
  localparam logic [2:0] ECLASS_MIN = 3'h2;
  localparam int unsigned PULSE_GAP_HALVES = 4;
  // Lamp colour codes: bit1 red, bit0 green
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_GREEN = 2'h1;
  localparam logic [1:0] LAMP_RED = 2'h2;
  typedef enum logic [1:0] {SFM_RUN, SFM_REPAIR, SFM_CONFIG, SFM_CRITICAL} sfm_level_e;
endpackage

/* sfm_flash_div.sv */
// Programmable flash divider: toggles a 50 % square wave every half_cyc cycles.
// Assumes restart pulses from the owner whenever the pattern must begin afresh.
`timescale 1ns/100ps
`default_nettype none
module sfm_flash_div
(
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [sfm_pkg::DIV_W-1:0] half_cyc,
  output logic phase,
  output logic edge_pulse
);
  import sfm_pkg::*;
  logic [DIV_W-1:0] cnt_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      phase <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else if (restart)
    begin
      cnt_r <= '0;
      phase <= 1'b1;
      edge_pulse <= 1'b0;
    end
    else if (cnt_r + 1'b1 >= half_cyc)
    begin
      cnt_r <= '0;
      phase <= ~phase;
      edge_pulse <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      edge_pulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sfm_fault_mgr.sv */
// Fault-state manager: sorts faults into levels, gates safety outputs and
// process data, drives module status and supply/error lamps.
// Assumes synchronous fault inputs; rst is the power-on reset, and
// supply_ok low marks supply removal seen by a monitor on this clock.
//
// Overview of operation
// - Configuration error: configuration-required state, module lamp red flashing at 1 Hz.
// - Configuration or critical error: stop apps, all outputs off, all data zero.
// - Repairable error: apps run, affected lamp red/green 1 Hz, others green.
// - Repairable error: affected outputs off, affected safe input data zeroed.
// - Critical error: detecting module red 2 Hz, others steady red.
// - Critical error latched until supply removed at least 3 s, then restored.
// - Input error clears when input or pair reaches safe state after cause gone.
// - Antivalent pairs may need active then inactive before error clears.
// - Output error clears only when both pair outputs driven inactive together.
// - Output pairs fixed: outputs 1/2, 3/4, and two combined I/O pairs.
// - Controller error: supply lamp red, pulse count equals error class 2 to 7.
`timescale 1ns/100ps
`default_nettype none
module sfm_fault_mgr
#(
  parameter int unsigned PWR_OFF_CYCLES = sfm_pkg::PWR_OFF_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic config_err,
  input wire logic critical_err,
  input wire logic critical_local,
  input wire logic repair_local,
  input wire logic [sfm_pkg::NUM_OUT-1:0] out_fault,
  input wire logic [sfm_pkg::NUM_IN-1:0] in_fault,
  input wire logic [sfm_pkg::NUM_IN/2-1:0] in_antivalent,
  input wire logic [sfm_pkg::NUM_IN-1:0] in_level,
  input wire logic [sfm_pkg::NUM_OUT-1:0] logic_out,
  input wire logic [sfm_pkg::NUM_IN-1:0] in_data,
  input wire logic [7:0] nonsafe_data,
  input wire logic [2:0] ctrl_err_class,
  input wire logic [sfm_pkg::DIV_W-1:0] slow_half_cyc,
  input wire logic [sfm_pkg::DIV_W-1:0] fast_half_cyc,
  output logic [1:0] level,
  output logic apps_run,
  output logic [sfm_pkg::NUM_OUT-1:0] safe_out,
  output logic [sfm_pkg::NUM_IN-1:0] safe_data,
  output logic [7:0] nonsafe_out,
  output logic [1:0] module_status_lamp,
  output logic supply_error_lamp,
  output logic [sfm_pkg::NUM_PAIR-1:0] out_err,
  output logic [sfm_pkg::NUM_IN/2-1:0] in_err
);
  import sfm_pkg::*;

  sfm_level_e level_r;
  sfm_level_e level_nxt;
  logic crit_r;
  logic crit_src_r;
  logic cfg_r;
  logic [31:0] off_cnt_r;
  logic off_long_r;
  logic [NUM_PAIR-1:0] out_err_r;
  logic [NUM_IN/2-1:0] in_err_r;
  logic [NUM_IN/2-1:0] av_seen_r;
  logic restart;
  logic slow_ph;
  logic fast_ph;
  logic slow_edge;
  logic [3:0] pulse_r;
  logic [3:0] gap_r;
  logic [NUM_PAIR-1:0] out_fault_pair;

  // Pair index of each output: 0,1 -> pair 0; ... 6,7 -> pair 3
  function automatic logic [NUM_PAIR-1:0] pair_or(input logic [NUM_OUT-1:0] v);
    logic [NUM_PAIR-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_PAIR; i++)
      r[i] = v[2*i] | v[2*i+1];
    return r;
  endfunction

  function automatic logic [NUM_OUT-1:0] pair_expand(input logic [NUM_PAIR-1:0] p);
    logic [NUM_OUT-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_PAIR; i++)
    begin
      r[2*i] = p[i];
      r[2*i+1] = p[i];
    end
    return r;
  endfunction

  // Critical latch: only supply removal long enough clears it; rst is power-on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      off_cnt_r <= '0;
      off_long_r <= 1'b0;
    end
    else if (!supply_ok)
    begin
      if (off_cnt_r + 32'h1 >= PWR_OFF_CYCLES[31:0])
        off_long_r <= 1'b1;
      else
        off_cnt_r <= off_cnt_r + 32'h1;
    end
    else
    begin
      off_cnt_r <= '0;
      off_long_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      crit_r <= 1'b0;
      crit_src_r <= 1'b0;
    end
    else if (critical_err)
    begin
      // A new error wins over a simultaneous clear
      crit_r <= 1'b1;
      crit_src_r <= crit_src_r | critical_local;
    end
    else if (supply_ok && off_long_r)
    begin
      crit_r <= 1'b0;
      crit_src_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cfg_r <= 1'b0;
    else
      cfg_r <= config_err;
  end

  always_comb
  begin
    if (crit_r || critical_err)
      level_nxt = SFM_CRITICAL;
    else if (cfg_r)
      level_nxt = SFM_CONFIG;
    else if ((|out_err_r) || (|in_err_r) || repair_local)
      level_nxt = SFM_REPAIR;
    else
      level_nxt = SFM_RUN;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      level_r <= SFM_RUN;
    else
      level_r <= level_nxt;
  end

  assign out_fault_pair = pair_or(out_fault);

  // Output pair errors: set by a fault, cleared only with both outputs low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      out_err_r <= '0;
    else
    begin
      for (int p = 0; p < NUM_PAIR; p++)
      begin
        if (out_fault_pair[p])
          out_err_r[p] <= 1'b1;
        else if (!logic_out[2*p] && !logic_out[2*p+1])
          out_err_r[p] <= 1'b0;
      end
    end
  end

  // Input pair errors: safe state is both channels low, or first low and second high for antivalent; antivalent pairs
  // must first see the source go active (first channel high)
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_err_r <= '0;
      av_seen_r <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_IN/2; p++)
      begin
        if (in_fault[2*p] || in_fault[2*p+1])
        begin
          in_err_r[p] <= 1'b1;
          av_seen_r[p] <= 1'b0;
        end
        else if (in_err_r[p])
        begin
          if (in_antivalent[p])
          begin
            if (in_level[2*p] && !in_level[2*p+1])
              av_seen_r[p] <= 1'b1;
            else if (av_seen_r[p] && !in_level[2*p] && in_level[2*p+1])
              in_err_r[p] <= 1'b0;
          end
          else if (!in_level[2*p] && !in_level[2*p+1])
            in_err_r[p] <= 1'b0;
        end
      end
    end
  end

  // Gating of outputs and process data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      apps_run <= 1'b0;
      safe_out <= '0;
      safe_data <= '0;
      nonsafe_out <= '0;
    end
    else if (level_nxt == SFM_CRITICAL || level_nxt == SFM_CONFIG)
    begin
      apps_run <= 1'b0;
      safe_out <= '0;
      safe_data <= '0;
      nonsafe_out <= '0;
    end
    else
    begin
      apps_run <= 1'b1;
      safe_out <= logic_out & ~pair_expand(out_err_r | pair_or(out_fault));
      safe_data <= in_data & ~pair_expand(in_err_r | pair_or(in_fault));
      nonsafe_out <= nonsafe_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level <= 2'h0;
      out_err <= '0;
      in_err <= '0;
    end
    else
    begin
      level <= level_r;
      out_err <= out_err_r;
      in_err <= in_err_r;
    end
  end

  assign restart = (level_nxt != level_r);

  sfm_flash_div u_slow
  (
    .clk(clk),
    .rst(rst),
    .restart(restart),
    .half_cyc(slow_half_cyc),
    .phase(slow_ph),
    .edge_pulse(slow_edge)
  );

  sfm_flash_div u_fast
  (
    .clk(clk),
    .rst(rst),
    .restart(restart),
    .half_cyc(fast_half_cyc),
    .phase(fast_ph),
    .edge_pulse()
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      module_status_lamp <= LAMP_OFF;
    else
    begin
      case (level_r)
        SFM_CONFIG: module_status_lamp <= slow_ph ? LAMP_RED : LAMP_OFF;
        SFM_CRITICAL:
          if (crit_src_r)
            module_status_lamp <= fast_ph ? LAMP_RED : LAMP_OFF;
          else
            module_status_lamp <= LAMP_RED;
        SFM_REPAIR:
          if (repair_local || (|out_err_r) || (|in_err_r))
            module_status_lamp <= slow_ph ? LAMP_RED : LAMP_GREEN;
          else
            module_status_lamp <= LAMP_GREEN;
        SFM_RUN: module_status_lamp <= LAMP_GREEN;
        default: module_status_lamp <= LAMP_OFF;
      endcase
    end
  end

  // Supply/error lamp: class pulses on the slow clock, then a dark gap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pulse_r <= '0;
      gap_r <= '0;
      supply_error_lamp <= 1'b0;
    end
    else if (ctrl_err_class < ECLASS_MIN)
    begin
      pulse_r <= '0;
      gap_r <= '0;
      supply_error_lamp <= 1'b0;
    end
    else if (slow_edge)
    begin
      if (gap_r != 4'h0)
      begin
        gap_r <= gap_r - 4'h1;
        supply_error_lamp <= 1'b0;
      end
      else if (!supply_error_lamp)
      begin
        supply_error_lamp <= 1'b1;
        pulse_r <= pulse_r + 4'h1;
      end
      else
      begin
        supply_error_lamp <= 1'b0;
        if (pulse_r >= {1'b0, ctrl_err_class})
        begin
          pulse_r <= '0;
          gap_r <= PULSE_GAP_HALVES[3:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sfm_fault_mgr_properties.sv */
// Checker for the fault manager port timing.
// Assumes binding to sfm_fault_mgr; one clock, rst async active high.
`timescale 1ns/100ps
`default_nettype none
module sfm_fault_mgr_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic config_err,
  input wire logic critical_err,
  input wire logic [sfm_pkg::NUM_OUT-1:0] logic_out,
  input wire logic [1:0] level,
  input wire logic apps_run,
  input wire logic [sfm_pkg::NUM_OUT-1:0] safe_out,
  input wire logic [sfm_pkg::NUM_IN-1:0] safe_data,
  input wire logic [7:0] nonsafe_out,
  input wire logic [1:0] module_status_lamp,
  input wire logic [sfm_pkg::NUM_PAIR-1:0] out_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_CRIT_OFF: assert property (critical_err |=> !apps_run && safe_out == 8'h00)
    else $error("outputs live after critical error");
  AST_CRIT_LVL: assert property (critical_err |-> ##2 level == 2'h3)
    else $error("critical level not entered");
  AST_CRIT_HOLD: assert property ((supply_ok [*4] ##0 (level == 2'h3)) |=> level == 2'h3)
    else $error("critical level left with supply present");
  AST_CFG_OFF: assert property (config_err [*3] |-> !apps_run && nonsafe_out == 8'h00
    && safe_out == 8'h00 && safe_data == 8'h00) else $error("outputs live in config error");
  // Level output trails the error by three edges, one more than the gating
  AST_CFG_LVL: assert property (config_err [*3] |=> level[1])
    else $error("config level not entered");
  AST_CFG_LAMP: assert property ((level == 2'h2) [*3] |-> !module_status_lamp[0])
    else $error("green lamp in config level");
  AST_CRIT_LAMP: assert property ((level == 2'h3) [*3] |-> !module_status_lamp[0])
    else $error("green lamp in critical level");
  // Gating runs one edge ahead of the level output
  AST_REP_RUN: assert property (!apps_run |=> level != 2'h1)
    else $error("apps stopped in repair level");
  AST_OUT_HOLD: assert property (out_err[0] && $past(logic_out[1:0]) != 2'h0 |=> out_err[0])
    else $error("output error cleared with an output active");
  AST_PAIR_OFF: assert property (out_err[0] && $past(out_err[0]) |-> safe_out[1:0] == 2'h0)
    else $error("faulty pair still driven");
endmodule
`default_nettype wire

/* sfm_chan_model.sv */
// Far side model: input sensors and a watcher on the status lamp.
// Assumes the bench commands sensor states; counts red lamp onsets.
`timescale 1ns/100ps
`default_nettype none
module sfm_chan_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sensor_cmd,
  input wire logic [1:0] lamp,
  input wire logic sup_lamp,
  output logic [sfm_pkg::NUM_IN-1:0] in_level,
  output logic [15:0] red_rises,
  output logic [15:0] sup_rises
);
  logic red_r;
  logic sup_r;
  // Supply lamp pulses are counted the same way as red onsets
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sup_r <= 1'b0;
      sup_rises <= 16'h0000;
    end
    else
    begin
      sup_r <= sup_lamp;
      sup_rises <= sup_rises + 16'(sup_lamp & ~sup_r);
    end
  end
  // Contacts settle one clock after being commanded
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      in_level <= '0;
    else
      in_level <= sensor_cmd;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      red_r <= 1'b0;
    else
      red_r <= lamp[1];
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      red_rises <= 16'h0000;
    else
      red_rises <= red_rises + 16'(lamp[1] & ~red_r);
  end
endmodule
`default_nettype wire

/* sfm_fault_mgr_tb.sv */
// Bench for the fault manager: drives fault levels, checks gating and lamps.
// Assumes short flash and power-off counts so the run stays brief.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module sfm_fault_mgr_tb;
  import sfm_pkg::*;
  localparam int unsigned PWR_N = 20;
  int fails = 0;
  int samples_checked = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b1;
  logic config_err = 1'b0;
  logic critical_err = 1'b0;
  logic critical_local = 1'b0;
  logic repair_local = 1'b0;
  logic [7:0] out_fault = 8'h00;
  logic [7:0] in_fault = 8'h00;
  logic [7:0] logic_out = 8'h00;
  logic [7:0] in_data = 8'h00;
  logic [7:0] nonsafe_data = 8'ha5;
  logic [7:0] sensor_cmd = 8'h00;
  logic [7:0] in_level, safe_out, safe_data, nonsafe_out;
  logic [1:0] level, module_status_lamp;
  logic [3:0] out_err, in_err;
  logic apps_run, supply_error_lamp;
  logic [15:0] red_rises, r0, sup_rises;
  logic [2:0] err_class = 3'h0;
  logic [3:0] antival = 4'h0;
  always #5 clk = ~clk;
  sfm_fault_mgr #(.PWR_OFF_CYCLES(PWR_N)) dut_u (.clk(clk), .rst(rst), .supply_ok(supply_ok),
    .config_err(config_err), .critical_err(critical_err), .critical_local(critical_local),
    .repair_local(repair_local), .out_fault(out_fault), .in_fault(in_fault),
    .in_antivalent(antival), .in_level(in_level), .logic_out(logic_out), .in_data(in_data),
    .nonsafe_data(nonsafe_data), .ctrl_err_class(err_class), .slow_half_cyc(32'h0000000a),
    .fast_half_cyc(32'h00000005), .level(level), .apps_run(apps_run), .safe_out(safe_out),
    .safe_data(safe_data), .nonsafe_out(nonsafe_out), .module_status_lamp(module_status_lamp),
    .supply_error_lamp(supply_error_lamp), .out_err(out_err), .in_err(in_err));
  sfm_chan_model chan_u (.clk(clk), .rst(rst), .sensor_cmd(sensor_cmd),
    .lamp(module_status_lamp), .sup_lamp(supply_error_lamp), .in_level(in_level),
    .red_rises(red_rises), .sup_rises(sup_rises));
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_pairs();
    @(posedge clk);
    logic_out <= 8'hff;
    in_data <= 8'h5a;
    out_fault <= 8'h02;
    in_fault <= 8'h04;
    sensor_cmd <= 8'h0c;
    repair_local <= 1'b1;
    @(posedge clk);
    out_fault <= 8'h00;
    in_fault <= 8'h00;
    st(3);
    `CHK(out_err, 4'h1)
    `CHK(safe_out, 8'hfc)
    `CHK(safe_data, 8'h52)
    `CHK(apps_run, 1'b1)
    // Affected module alternates red and green, period two slow halves
    r0 = red_rises;
    st(40);
    `CHK(red_rises - r0 >= 16'h1 && red_rises - r0 <= 16'h3, 1'b1)
    `CHK(module_status_lamp == LAMP_OFF, 1'b0)
    @(posedge clk);
    logic_out <= 8'hfe;
    sensor_cmd <= 8'h04;
    st(4);
    `CHK(out_err, 4'h1)
    `CHK(in_err, 4'h2)
    @(posedge clk);
    logic_out <= 8'hfc;
    sensor_cmd <= 8'h00;
    repair_local <= 1'b0;
    st(4);
    `CHK(out_err, 4'h0)
    `CHK({in_err, safe_data}, 12'h05a)
    $display("pair test done");
  endtask
  // Pair 2 antivalent: inactive alone must not clear, active then inactive does
  task automatic t_antival();
    @(posedge clk);
    antival <= 4'h4;
    in_fault <= 8'h10;
    sensor_cmd <= 8'h20;
    @(posedge clk);
    in_fault <= 8'h00;
    st(4);
    `CHK({in_err, safe_data}, 12'h44a)
    @(posedge clk);
    sensor_cmd <= 8'h10;
    st(4);
    `CHK(in_err, 4'h4)
    @(posedge clk);
    sensor_cmd <= 8'h20;
    st(4);
    `CHK({in_err, safe_data, apps_run}, 13'h00b5)
    $display("antivalent test done");
  endtask
  // One burst plus gap spans (2*class+4) slow halves, so a window of that length
  // holds exactly class pulses whatever its phase
  task automatic t_class();
    @(posedge clk);
    err_class <= 3'h3;
    st(20);
    r0 = sup_rises;
    st(100);
    `CHK(sup_rises - r0, 16'h0003)
    @(posedge clk);
    err_class <= 3'h0;
    @(posedge clk);
    err_class <= 3'h7;
    st(20);
    r0 = sup_rises;
    st(180);
    `CHK(sup_rises - r0, 16'h0007)
    @(posedge clk);
    err_class <= 3'h1;
    st(2);
    r0 = sup_rises;
    st(60);
    `CHK({sup_rises - r0, supply_error_lamp}, 17'h00000)
    $display("class test done");
  endtask
  task automatic t_config();
    @(posedge clk);
    config_err <= 1'b1;
    st(4);
    `CHK({level, apps_run}, 3'h4)
    `CHK({safe_out, safe_data, nonsafe_out}, 24'h000000)
    r0 = red_rises;
    st(100);
    `CHK(red_rises - r0 >= 16'h4 && red_rises - r0 <= 16'h6, 1'b1)
    @(posedge clk);
    config_err <= 1'b0;
    st(6);
    `CHK({level, apps_run}, 3'h1)
    $display("config test done");
  endtask
  task automatic t_critical();
    @(posedge clk);
    critical_err <= 1'b1;
    critical_local <= 1'b1;
    @(posedge clk);
    critical_err <= 1'b0;
    st(4);
    `CHK({level, apps_run, safe_data}, 11'h600)
    r0 = red_rises;
    st(100);
    `CHK(red_rises - r0 >= 16'h9 && red_rises - r0 <= 16'hb, 1'b1)
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (PWR_N - 5) @(posedge clk);
    supply_ok <= 1'b1;
    st(6);
    `CHK(level, 2'h3)
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (PWR_N + 5) @(posedge clk);
    supply_ok <= 1'b1;
    st(6);
    `CHK({level, apps_run}, 3'h1)
    // A module that did not detect the cause shows steady red
    @(posedge clk);
    critical_local <= 1'b0;
    critical_err <= 1'b1;
    @(posedge clk);
    critical_err <= 1'b0;
    st(4);
    r0 = red_rises;
    st(30);
    `CHK({red_rises - r0, module_status_lamp}, 18'h00002)
    $display("critical test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_pairs();
    t_antival();
    t_class();
    t_config();
    t_critical();
    end_sim();
  end
  initial
  begin
    #20000;
    fails++;
    end_sim();
  end
endmodule
bind sfm_fault_mgr sfm_fault_mgr_properties chk_u (.clk(clk), .rst(rst), .supply_ok(supply_ok),
  .config_err(config_err), .critical_err(critical_err), .logic_out(logic_out), .level(level),
  .apps_run(apps_run), .safe_out(safe_out), .safe_data(safe_data), .nonsafe_out(nonsafe_out),
  .module_status_lamp(module_status_lamp), .out_err(out_err));
`default_nettype wire
